// ==== logic/ewc_pkg.sv ====
// Purpose: shared constants and types for the EEPROM write-cycle link
// Assumes: 40 MHz ref_clk; master makes SCL with a divider
// Notes:
// Contract
// [R1] Stop after full data byte starts programming
// [R2] Busy device ignores commands, gives no acknowledge
// [R3] Address acknowledge low only once write ended
// [R4] Master may poll instead of waiting 5ms
// [R5] Poll with RW bit of following command
// [R6] Write-protect ignored until data_bit_zero clock rise
// [R7] Write-protect high after data_bit_zero aborts write
// [R8] Forced write end returns device to standby
// [R9] Write-protect high refuses every rewrite
// [R10] Start then stop cancels command in entry
// [R11] Held SDA low needs software reset instead
// [R12] Software reset: start, nine clocks, start
// [R13] Cancelled read leaves address undefined; random read
// [R14] Power-on: SDA released high, SCL driven
// [R15] Bad power-up: lines high, then software reset
// [R16] Low supply inhibits all rewrites
// [R17] Unacknowledged poll: stop and retry, bounded
package ewc_pkg;
	localparam int EWC_CLK_NS = 25;
	localparam int EWC_WRITE_NS = 5000000;
	localparam int EWC_WRITE_CYC = EWC_WRITE_NS / EWC_CLK_NS;
	localparam int EWC_SCL_NS = 10000;
	localparam int EWC_QTR_CYC = EWC_SCL_NS / 4 / EWC_CLK_NS;
	localparam int EWC_POLL_MAX = EWC_WRITE_CYC / (EWC_QTR_CYC * 44) + 1;
	localparam int EWC_PAGE = 8;
	localparam int EWC_DEPTH = 256;
	localparam logic [3:0] EWC_DEV_TYPE = 4'hA;
	localparam logic [3:0] EWC_BIT_ACK = 4'h8;
	localparam logic [3:0] EWC_BIT_END = 4'h9;
	localparam logic [3:0] EWC_PIN_RST = 4'h7;
	localparam logic [7:0] EWC_DUMMY = 8'hFF;
	localparam logic [1:0] EWC_OP_WRITE = 2'h0;
	localparam logic [1:0] EWC_OP_READ = 2'h1;
	localparam logic [1:0] EWC_OP_SRST = 2'h2;

	typedef enum logic [4:0] {
		EWC_DS_IDLE = 5'b00001,
		EWC_DS_DEV = 5'b00010,
		EWC_DS_WADR = 5'b00100,
		EWC_DS_WDAT = 5'b01000,
		EWC_DS_RDAT = 5'b10000
	} ewc_dstate_t;

	typedef enum logic [3:0] {
		EWC_HA_START = 4'b0001,
		EWC_HA_BYTE = 4'b0010,
		EWC_HA_STOP = 4'b0100,
		EWC_HA_END = 4'b1000
	} ewc_hact_t;

	typedef enum logic [1:0] {
		EWC_HS_IDLE = 2'b01,
		EWC_HS_RUN = 2'b10
	} ewc_hstate_t;
endpackage

// ==== logic/ewc_link_if.sv ====
// Purpose: two-wire link between bus master and EEPROM end
// Assumes: SDA open drain with pull-up, SCL driven by the master
// Notes: line level resolved here from both enables
`timescale 1ns/100ps
`default_nettype none
interface ewc_link_if;
	logic scl;
	logic sda_host_oe;
	logic sda_dev_oe;
	logic sda_line;

	// Pull-up wins unless someone pulls low
	assign sda_line = !(sda_host_oe || sda_dev_oe);

	modport dev (input scl, input sda_line, output sda_dev_oe);
	modport host (output scl, output sda_host_oe, input sda_line);
endinterface
`default_nettype wire

// ==== logic/ewc_eeprom_dev.sv ====
// Purpose: EEPROM end: command decode, write cycle, polling, cancel
// Assumes: SCL slow against ref_clk; pins pass three flip-flops
// Notes: memory held in a local array, one page buffered per write
`timescale 1ns/100ps
`default_nettype none
module ewc_eeprom_dev #(
	parameter int WRITE_CYCLES = ewc_pkg::EWC_WRITE_CYC,
	parameter int PAGE = ewc_pkg::EWC_PAGE,
	parameter int DEPTH = ewc_pkg::EWC_DEPTH
) (
	input wire logic ref_clk,
	input wire logic rst,
	ewc_link_if.dev link,
	input wire logic [2:0] chip_sel,
	input wire logic wp,
	input wire logic low_voltage_write_inhibit,
	output logic write_busy,
	output logic write_aborted
);
	localparam int AW = $clog2(DEPTH);
	localparam int PW = $clog2(PAGE);

	logic [3:0] pin_raw;
	logic [3:0] s1_q, s2_q, s3_q, flt_q, prev_q;
	logic [3:0] agree;
	logic scl_s, sda_s, wp_s, lv_s;
	logic scl_rise, scl_fall, start_ev, stop_ev;

	ewc_pkg::ewc_dstate_t state_q;
	logic [3:0] bit_q;
	logic [7:0] sr_q, tx_q;
	logic [AW-1:0] addr_q;
	logic rw_q, oe_q, mnack_q;
	logic [7:0] mem [DEPTH];
	logic [7:0] pbuf [PAGE];
	logic [PAGE-1:0] pvalid_q;
	logic [PW-1:0] off;
	logic wp_arm_q, wp_kill_q, abort_q;
	logic [31:0] busy_cnt_q;
	logic busy_q;
	logic [PAGE-1:0] wmask_q;
	logic [AW-PW-1:0] wpage_q;
	logic dev_match, arm_set, commit_ok, commit_now;

	assign pin_raw = {low_voltage_write_inhibit, wp, link.sda_line, link.scl};
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s1_q <= ewc_pkg::EWC_PIN_RST;
			s2_q <= ewc_pkg::EWC_PIN_RST;
			s3_q <= ewc_pkg::EWC_PIN_RST;
			flt_q <= ewc_pkg::EWC_PIN_RST;
			prev_q <= ewc_pkg::EWC_PIN_RST;
		end else begin
			s1_q <= pin_raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
			flt_q <= (agree & s3_q) | (~agree & flt_q);
			prev_q <= flt_q;
		end
	end

	// A level counts only once second and third stage agree
	assign agree = ~(s2_q ^ s3_q);
	assign scl_s = flt_q[0];
	assign sda_s = flt_q[1];
	assign wp_s = flt_q[2];
	assign lv_s = flt_q[3];
	assign scl_rise = scl_s & ~prev_q[0];
	assign scl_fall = ~scl_s & prev_q[0];
	assign start_ev = scl_s & prev_q[0] & prev_q[1] & ~sda_s;
	assign stop_ev = scl_s & prev_q[0] & ~prev_q[1] & sda_s;

	assign dev_match = (sr_q[7:1] == {ewc_pkg::EWC_DEV_TYPE, chip_sel});
	assign off = addr_q[PW-1:0];
	assign arm_set = scl_rise && state_q == ewc_pkg::EWC_DS_WDAT &&
		bit_q == 4'h7 && pvalid_q == '0; // R6
	// Program only when stop lands right after a full data byte;
	// the stop's own SCL rise has already counted one bit
	assign commit_ok = stop_ev && state_q == ewc_pkg::EWC_DS_WDAT &&
		bit_q == 4'h1 && pvalid_q != '0; // R1 R10
	assign commit_now = commit_ok && !wp_kill_q && !wp_s && !lv_s; // R7 R9 R16

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_q <= ewc_pkg::EWC_DS_IDLE;
			bit_q <= 4'h0;
			sr_q <= 8'h00;
			tx_q <= 8'h00;
			addr_q <= '0;
			rw_q <= 1'b0;
			oe_q <= 1'b0;
			mnack_q <= 1'b0;
			pvalid_q <= '0;
		end else if (start_ev) begin
			// A start mid-command drops whatever was entered
			state_q <= ewc_pkg::EWC_DS_DEV;
			bit_q <= 4'h0;
			oe_q <= 1'b0;
			mnack_q <= 1'b0;
			pvalid_q <= '0;
		end else if (stop_ev) begin
			// Cancelled read leaves addr_q wherever it got to
			state_q <= ewc_pkg::EWC_DS_IDLE; // R8 R10 R13
			oe_q <= 1'b0;
		end else if (scl_rise && state_q != ewc_pkg::EWC_DS_IDLE) begin
			if (bit_q < ewc_pkg::EWC_BIT_END)
				bit_q <= bit_q + 4'h1;
			if (bit_q < ewc_pkg::EWC_BIT_ACK)
				sr_q <= {sr_q[6:0], sda_s};
			if (bit_q == ewc_pkg::EWC_BIT_ACK && sda_s)
				mnack_q <= 1'b1;
		end else if (scl_fall && state_q != ewc_pkg::EWC_DS_IDLE) begin
			if (bit_q == ewc_pkg::EWC_BIT_ACK) begin
				case (state_q)
				ewc_pkg::EWC_DS_DEV: begin
					if (dev_match && !busy_q) begin
						oe_q <= 1'b1; // R3
						rw_q <= sr_q[0];
						tx_q <= mem[addr_q];
						if (sr_q[0])
							addr_q <= addr_q + 1'b1;
					end else begin
						state_q <= ewc_pkg::EWC_DS_IDLE; // R2 R3
					end
				end
				ewc_pkg::EWC_DS_WADR: begin
					addr_q <= sr_q[AW-1:0];
					oe_q <= 1'b1;
					state_q <= ewc_pkg::EWC_DS_WDAT;
				end
				ewc_pkg::EWC_DS_WDAT: begin
					// Page offset wraps, so excess bytes overwrite
					pbuf[off] <= sr_q;
					pvalid_q[off] <= 1'b1;
					addr_q[PW-1:0] <= off + 1'b1;
					oe_q <= 1'b1;
				end
				ewc_pkg::EWC_DS_RDAT: begin
					oe_q <= 1'b0;
					tx_q <= mem[addr_q];
					addr_q <= addr_q + 1'b1;
				end
				default: state_q <= ewc_pkg::EWC_DS_IDLE;
				endcase
			end else if (bit_q == ewc_pkg::EWC_BIT_END) begin
				bit_q <= 4'h0;
				oe_q <= 1'b0;
				mnack_q <= 1'b0;
				case (state_q)
				ewc_pkg::EWC_DS_DEV: begin
					if (rw_q) begin
						state_q <= ewc_pkg::EWC_DS_RDAT;
						oe_q <= ~tx_q[7];
					end else begin
						state_q <= ewc_pkg::EWC_DS_WADR;
					end
				end
				ewc_pkg::EWC_DS_RDAT: begin
					if (mnack_q)
						state_q <= ewc_pkg::EWC_DS_IDLE;
					else
						oe_q <= ~tx_q[7];
				end
				default: oe_q <= 1'b0;
				endcase
			end else if (state_q == ewc_pkg::EWC_DS_RDAT) begin
				oe_q <= ~tx_q[3'(7 - bit_q)];
			end
		end
	end

	// Write-protect watch window runs from D0 rise to the stop
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wp_arm_q <= 1'b0;
			wp_kill_q <= 1'b0;
			abort_q <= 1'b0;
		end else begin
			wp_arm_q <= !start_ev && !stop_ev && (wp_arm_q || arm_set);
			wp_kill_q <= !start_ev && (wp_kill_q || (wp_arm_q && wp_s)); // R7
			if (start_ev)
				abort_q <= 1'b0;
			else if (commit_ok && (wp_kill_q || wp_s))
				abort_q <= 1'b1; // R7 R8
		end
	end

	// Page latched at commit: polls during the write clear entry state
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			busy_cnt_q <= 32'h0;
			busy_q <= 1'b0;
			wmask_q <= '0;
			wpage_q <= '0;
		end else begin
			if (commit_now && !busy_q) begin
				busy_cnt_q <= 32'(WRITE_CYCLES);
				wmask_q <= pvalid_q;
				wpage_q <= addr_q[AW-1:PW];
			end else if (busy_cnt_q != 32'h0) begin
				busy_cnt_q <= busy_cnt_q - 32'h1;
			end
			busy_q <= (commit_now && !busy_q) || busy_cnt_q > 32'h1;
		end
	end

	// Cells change only at the end of the write time
	always_ff @(posedge ref_clk) begin
		if (busy_cnt_q == 32'h1 && !lv_s && !wp_s) begin // R9 R16
			for (int i = 0; i < PAGE; i++) begin
				if (wmask_q[i])
					mem[{wpage_q, PW'(i)}] <= pbuf[i];
			end
		end
	end

	assign link.sda_dev_oe = oe_q;
	assign write_busy = busy_q;
	assign write_aborted = abort_q;
endmodule // ewc_eeprom_dev
`default_nettype wire

// ==== logic/ewc_bus_master.sv ====
// Purpose: bus master end: write, random read, software reset
// Assumes: SCL made here from ref_clk by a quarter-period divider
// Notes: write and read poll their first device address until acknowledged, retrying up to POLL_MAX times
`timescale 1ns/100ps
`default_nettype none
module ewc_bus_master #(
	parameter int QTR = ewc_pkg::EWC_QTR_CYC,
	parameter int POLL_MAX = ewc_pkg::EWC_POLL_MAX
) (
	input wire logic ref_clk,
	input wire logic rst,
	ewc_link_if.host link,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic [1:0] cmd_op,
	input wire logic [2:0] cmd_chip,
	input wire logic [7:0] cmd_addr,
	input wire logic [7:0] cmd_wdata,
	output logic rsp_valid,
	output logic [7:0] rsp_rdata,
	output logic rsp_err
);
	ewc_pkg::ewc_hstate_t hs_q;
	ewc_pkg::ewc_hact_t act;
	logic [1:0] op_q, q_q;
	logic [2:0] chip_q, step_q;
	logic [7:0] addr_q, data_q, rx_q, txb;
	logic [15:0] qcnt_q, poll_q;
	logic [3:0] bit_q;
	logic scl_q, oe_q, nack_q, stopping_q, retry_q;
	logic tick, rd_byte, chk_ack, poll_pt, last_q, rx_bit;

	assign tick = (qcnt_q == 16'(QTR - 1));
	assign last_q = tick && q_q == 2'h3;
	assign cmd_ready = (hs_q == ewc_pkg::EWC_HS_IDLE);
	assign rx_bit = link.sda_line;

	always_comb begin
		act = ewc_pkg::EWC_HA_END;
		txb = ewc_pkg::EWC_DUMMY;
		rd_byte = 1'b0;
		chk_ack = 1'b1;
		poll_pt = 1'b0;
		case ({op_q, step_q})
		{ewc_pkg::EWC_OP_WRITE, 3'h0}, {ewc_pkg::EWC_OP_READ, 3'h0},
		{ewc_pkg::EWC_OP_READ, 3'h3}, {ewc_pkg::EWC_OP_SRST, 3'h0},
		{ewc_pkg::EWC_OP_SRST, 3'h2}: act = ewc_pkg::EWC_HA_START;
		// Random read polls with RW 0 since the address follows
		{ewc_pkg::EWC_OP_WRITE, 3'h1}, {ewc_pkg::EWC_OP_READ, 3'h1}: begin
			act = ewc_pkg::EWC_HA_BYTE;
			txb = {ewc_pkg::EWC_DEV_TYPE, chip_q, 1'b0}; // R5 R13
			poll_pt = 1'b1; // R4
		end
		{ewc_pkg::EWC_OP_WRITE, 3'h2}, {ewc_pkg::EWC_OP_READ, 3'h2}: begin
			act = ewc_pkg::EWC_HA_BYTE;
			txb = addr_q;
		end
		{ewc_pkg::EWC_OP_WRITE, 3'h3}: begin
			act = ewc_pkg::EWC_HA_BYTE;
			txb = data_q;
		end
		{ewc_pkg::EWC_OP_READ, 3'h4}: begin
			act = ewc_pkg::EWC_HA_BYTE;
			txb = {ewc_pkg::EWC_DEV_TYPE, chip_q, 1'b1};
		end
		// Released SDA with no acknowledge expected
		{ewc_pkg::EWC_OP_READ, 3'h5}, {ewc_pkg::EWC_OP_SRST, 3'h1}: begin
			act = ewc_pkg::EWC_HA_BYTE;
			rd_byte = 1'b1;
			chk_ack = 1'b0; // R11 R12
		end
		{ewc_pkg::EWC_OP_WRITE, 3'h4}, {ewc_pkg::EWC_OP_READ, 3'h6},
		{ewc_pkg::EWC_OP_SRST, 3'h3}: act = ewc_pkg::EWC_HA_STOP;
		default: act = ewc_pkg::EWC_HA_END;
		endcase
		if (stopping_q)
			act = ewc_pkg::EWC_HA_STOP;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			qcnt_q <= 16'h0;
		else if (hs_q == ewc_pkg::EWC_HS_IDLE || tick)
			qcnt_q <= 16'h0;
		else
			qcnt_q <= qcnt_q + 16'h1;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			hs_q <= ewc_pkg::EWC_HS_IDLE;
			scl_q <= 1'b1; // R14
			oe_q <= 1'b0; // R14 R15
			{op_q, chip_q, addr_q, data_q} <= 21'h0;
			{q_q, step_q, bit_q} <= 9'h0;
			{rx_q, poll_q} <= 24'h0;
			{nack_q, stopping_q, retry_q} <= 3'h0;
			{rsp_valid, rsp_rdata, rsp_err} <= 10'h0;
		end else begin
			rsp_valid <= 1'b0;
			if (hs_q == ewc_pkg::EWC_HS_IDLE) begin
				if (cmd_valid) begin
					hs_q <= ewc_pkg::EWC_HS_RUN;
					{op_q, chip_q, addr_q, data_q} <=
						{cmd_op, cmd_chip, cmd_addr, cmd_wdata};
					{q_q, step_q, bit_q} <= 9'h0;
					{poll_q, nack_q, retry_q} <= 18'h0;
				end
			end else if (tick) begin
				q_q <= q_q + 2'h1;
				case (act)
				ewc_pkg::EWC_HA_START: begin
					scl_q <= (q_q == 2'h1 || q_q == 2'h2);
					if (q_q == 2'h0)
						oe_q <= 1'b0;
					if (q_q == 2'h2)
						oe_q <= 1'b1;
					if (last_q)
						step_q <= step_q + 3'h1;
				end
				ewc_pkg::EWC_HA_STOP: begin
					scl_q <= (q_q != 2'h0);
					if (q_q == 2'h0)
						oe_q <= 1'b1;
					if (q_q == 2'h2)
						oe_q <= 1'b0;
					if (last_q) begin
						stopping_q <= 1'b0;
						// Unacknowledged poll: stop, then start over
						if (retry_q) begin
							step_q <= 3'h0; // R17
							retry_q <= 1'b0;
						end else begin
							step_q <= step_q + 3'h1;
						end
					end
				end
				ewc_pkg::EWC_HA_BYTE: begin
					scl_q <= (q_q == 2'h1 || q_q == 2'h2);
					if (q_q == 2'h0)
						oe_q <= (bit_q < 4'h8) && !rd_byte &&
							!txb[3'(7 - bit_q)];
					if (q_q == 2'h2 && bit_q < 4'h8)
						rx_q <= {rx_q[6:0], rx_bit};
					if (q_q == 2'h2 && bit_q == 4'h8)
						nack_q <= rx_bit;
					if (last_q) begin
						bit_q <= (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
						if (bit_q == 4'h8) begin
							if (chk_ack && nack_q) begin
								stopping_q <= 1'b1;
								retry_q <= poll_pt &&
									poll_q < 16'(POLL_MAX); // R17
								poll_q <= poll_q + 16'h1;
								rsp_err <= !(poll_pt &&
									poll_q < 16'(POLL_MAX));
							end else begin
								step_q <= step_q + 3'h1;
							end
						end
					end
				end
				default: begin
					// Error path skips the remaining steps
					hs_q <= ewc_pkg::EWC_HS_IDLE;
					rsp_valid <= 1'b1;
					rsp_rdata <= rx_q;
					scl_q <= 1'b1;
					oe_q <= 1'b0;
				end
				endcase
				if (act == ewc_pkg::EWC_HA_STOP && last_q && !retry_q &&
					rsp_err)
					step_q <= 3'h7;
			end
			if (hs_q == ewc_pkg::EWC_HS_IDLE && cmd_valid)
				rsp_err <= 1'b0;
		end
	end

	assign link.scl = scl_q;
	assign link.sda_host_oe = oe_q;
endmodule // ewc_bus_master
`default_nettype wire

// ==== testbench/ewc_link_monitor.sv ====
// Purpose: link and write-cycle checks beside the joined link
// Assumes: one ref_clk domain, rst async high
// Notes: counters stand in for long repetitions
`timescale 1ns/100ps
`default_nettype none
module ewc_link_monitor #(
	parameter int WRITE_CYCLES = 200
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic scl,
	input wire logic sda_host_oe,
	input wire logic sda_dev_oe,
	input wire logic sda_line,
	input wire logic write_busy,
	input wire logic write_aborted,
	input wire logic wp
);
	logic sda_q, scl_q;
	logic [7:0] stop_age_q, wp_age_q, stop_age_d, wp_age_d;
	logic [19:0] busy_cnt_q, busy_cnt_d;
	wire stop_ev = scl && scl_q && sda_line && !sda_q;
	wire start_ev = scl && scl_q && !sda_line && sda_q;
	// Ages saturate so a long idle never wraps to a false match
	assign stop_age_d = stop_ev ? 8'h00 : stop_age_q + {7'h00, ~&stop_age_q};
	assign wp_age_d = wp ? 8'h00 : wp_age_q + {7'h00, ~&wp_age_q};
	assign busy_cnt_d = write_busy ? busy_cnt_q + 20'h00001 : 20'h00000;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			{sda_q, scl_q} <= 2'h3;
			{stop_age_q, wp_age_q} <= 16'hFFFF;
			busy_cnt_q <= 20'h00000;
		end else begin
			{sda_q, scl_q} <= {sda_line, scl};
			{stop_age_q, wp_age_q} <= {stop_age_d, wp_age_d};
			busy_cnt_q <= busy_cnt_d;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	AST_BUSY_SILENT: assert property (write_busy |-> !sda_dev_oe)
		else $error("device drove SDA while busy");
	AST_BUSY_FROM_STOP: assert property ($rose(write_busy) |->
		stop_age_q < 8'h10) else $error("write began without stop");
	AST_BUSY_LENGTH: assert property ($fell(write_busy) |->
		busy_cnt_q + 1 >= WRITE_CYCLES && busy_cnt_q <= WRITE_CYCLES + 1)
		else $error("write cycle length wrong");
	AST_DRIVE_SCL_LOW: assert property ($rose(sda_dev_oe) |-> !scl)
		else $error("device pulled SDA with SCL high");
	AST_ABORT_CAUSE: assert property ($rose(write_aborted) |->
		wp_age_q < 8'h40) else $error("abort without protect");
	AST_ABORT_STANDBY: assert property (write_aborted |->
		!write_busy && !sda_dev_oe) else $error("aborted device not idle");
	AST_START_CLEARS: assert property (start_ev && write_aborted |->
		##[1:8] !write_aborted) else $error("abort flag stuck");
	AST_RESET_IDLE: assert property ($fell(rst) |->
		scl && sda_line && !write_busy) else $error("lines not idle");
endmodule // ewc_link_monitor
`default_nettype wire

// ==== testbench/eeprom_write_cycle_status_cancel_tb.sv ====
// Purpose: both link ends joined; writes, polls, protect, reset
// Assumes: short write cycle and fast SCL for run time
// Notes: expectations kept in a shadow memory
`timescale 1ns/100ps
`default_nettype none
module eeprom_write_cycle_status_cancel_tb;
	// Long enough that the first read after a write is refused twice
	localparam int WCYC = 800;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic [2:0] chip_sel = 3'h5;
	logic wp = 1'b0;
	logic low_voltage_write_inhibit = 1'b0;
	logic write_busy, write_aborted, cmd_ready, rsp_valid, rsp_err, r_err;
	logic cmd_valid = 1'b0;
	logic [1:0] cmd_op = 2'h0;
	logic [2:0] cmd_chip = 3'h5;
	logic [7:0] cmd_addr = 8'h00;
	logic [7:0] cmd_wdata = 8'h00;
	logic [7:0] rsp_rdata, r_data, a, d;
	logic [7:0] mem_exp [256];
	int n_mismatch = 0;
	int tests_run = 0;
	int seed = 32'h2AD1;
	int k;

	ewc_link_if link ();
	always #12.5 ref_clk = ~ref_clk;

	ewc_eeprom_dev #(.WRITE_CYCLES(WCYC), .PAGE(8), .DEPTH(256)) u_ewc_eeprom_dev (
		.ref_clk(ref_clk), .rst(rst), .link(link), .chip_sel(chip_sel),
		.wp(wp), .low_voltage_write_inhibit(low_voltage_write_inhibit),
		.write_busy(write_busy), .write_aborted(write_aborted));
	ewc_bus_master #(.QTR(8), .POLL_MAX(4)) u_ewc_bus_master (
		.ref_clk(ref_clk), .rst(rst), .link(link), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_chip(cmd_chip),
		.cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
		.rsp_rdata(rsp_rdata), .rsp_err(rsp_err));
	ewc_link_monitor #(.WRITE_CYCLES(WCYC)) u_ewc_link_monitor (
		.ref_clk(ref_clk), .rst(rst), .scl(link.scl),
		.sda_host_oe(link.sda_host_oe), .sda_dev_oe(link.sda_dev_oe),
		.sda_line(link.sda_line), .write_busy(write_busy),
		.write_aborted(write_aborted), .wp(wp));

	// A protected or starved write leaves the cell as it was
	function automatic logic [7:0] exp_after(logic [7:0] old, logic [7:0] nw,
		logic prot);
		return prot ? old : nw;
	endfunction

	task automatic close_out();
		$display("mismatches %0d checks %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp,
		input string what);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic run_cmd(input logic [1:0] op, input logic [7:0] ad,
		input logic [7:0] wd);
		@(negedge ref_clk);
		chk({7'h00, cmd_ready}, 8'h01, "master not ready");
		cmd_op = op;
		cmd_addr = ad;
		cmd_wdata = wd;
		cmd_valid = 1'b1;
		@(negedge ref_clk);
		cmd_valid = 1'b0;
		chk({7'h00, cmd_ready}, 8'h00, "command not taken");
		for (k = 0; k < 20000 && rsp_valid !== 1'b1; k++)
			@(negedge ref_clk);
		chk({7'h00, k == 20000}, 8'h00, "no response");
		r_data = rsp_rdata;
		r_err = rsp_err;
	endtask

	task automatic wr(input logic [7:0] ad, input logic [7:0] wd,
		input logic prot);
		run_cmd(ewc_pkg::EWC_OP_WRITE, ad, wd);
		mem_exp[ad] = exp_after(mem_exp[ad], wd, prot);
	endtask

	task automatic rd_chk(input logic [7:0] ad);
		run_cmd(ewc_pkg::EWC_OP_READ, ad, 8'h00);
		chk(r_data, mem_exp[ad], "read data");
		chk({7'h00, r_err}, 8'h00, "read gave up");
	endtask

	initial begin
		repeat (90000) @(posedge ref_clk);
		n_mismatch++;
		$display("BAD %0t watchdog expired", $time);
		close_out();
	end

	initial begin
		repeat (8) @(posedge ref_clk);
		@(negedge ref_clk);
		rst = 1'b0;
		// Edges of the space first, then random cells
		for (int i = 0; i < 7; i++) begin
			a = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($random(seed));
			d = 8'($random(seed));
			wr(a, d, 1'b0);
			chk({7'h00, r_err}, 8'h00, "write gave up");
			for (k = 0; k < 16 && write_busy !== 1'b1; k++)
				@(negedge ref_clk);
			chk({7'h00, write_busy}, 8'h01, "no write cycle");
			// Read at once: only polling can see it through
			rd_chk(a);
		end
		$display("test random write and poll done");
		cmd_chip = 3'h2;
		run_cmd(ewc_pkg::EWC_OP_READ, a, 8'h00);
		chk({7'h00, r_err}, 8'h01, "foreign chip answered");
		cmd_chip = 3'h5;
		$display("test foreign chip done");
		wp = 1'b1;
		wr(a, ~mem_exp[a], 1'b1);
		for (k = 0; k < 16 && write_aborted !== 1'b1; k++)
			@(negedge ref_clk);
		chk({7'h00, write_aborted}, 8'h01, "no abort flag");
		chk({7'h00, write_busy}, 8'h00, "protected write ran");
		wp = 1'b0;
		rd_chk(a);
		$display("test protect done");
		d = 8'($random(seed));
		wp = 1'b1;
		fork
			wr(a, d, 1'b0);
			begin
				repeat (300) @(negedge ref_clk);
				wp = 1'b0;
			end
		join
		rd_chk(a);
		$display("test protect blind window done");
		low_voltage_write_inhibit = 1'b1;
		wr(a, ~d, 1'b1);
		chk({7'h00, write_busy}, 8'h00, "starved write ran");
		repeat (WCYC + 20) @(negedge ref_clk);
		low_voltage_write_inhibit = 1'b0;
		rd_chk(a);
		$display("test low supply done");
		run_cmd(ewc_pkg::EWC_OP_SRST, 8'h00, 8'h00);
		chk({7'h00, r_err}, 8'h00, "reset gave up");
		rd_chk(8'h00);
		$display("test software reset done");
		close_out();
	end
endmodule // eeprom_write_cycle_status_cancel_tb
`default_nettype wire
